//--- rtl/arc_pkg.sv
// package: register map, field layout and carrier types of the converter result controller
package arc_pkg;
  // bus geometry
  localparam int unsigned AW = 5;
  localparam int unsigned DW = 32;
  localparam int unsigned RES_W = 12;
  localparam int unsigned CH_W = 5;
  // register byte offsets
  localparam logic [AW-1:0] SC1_OFF = 5'h00;
  localparam logic [AW-1:0] CFG_OFF = 5'h04;
  localparam logic [AW-1:0] RESH_OFF = 5'h08;
  localparam logic [AW-1:0] RESL_OFF = 5'h0C;
  localparam logic [AW-1:0] IST_OFF = 5'h10;
  localparam logic [AW-1:0] ICLR_OFF = 5'h14;
  localparam logic [AW-1:0] IEN_OFF = 5'h18;
  // converter_status_control_one fields
  localparam int unsigned SC1_FLAG_BIT = 7;
  localparam int unsigned SC1_AIEN_BIT = 6;
  localparam int unsigned SC1_CONT_BIT = 5;
  localparam int unsigned SC1_CH_LSB = 0;
  localparam logic [CH_W-1:0] CH_OFF = 5'h1F;
  // configuration fields
  localparam int unsigned CFG_MODE_LSB = 0;
  localparam int unsigned CFG_CLKSEL_BIT = 2;
  localparam int unsigned CFG_BUSY_BIT = 7;
  // interrupt status fields
  localparam int unsigned IRQ_N = 2;
  localparam int unsigned IST_DONE_BIT = 0;
  localparam int unsigned IST_OVR_BIT = 1;
  // reset values
  localparam logic [CH_W-1:0] CH_RST = 5'h1F;
  localparam logic [IRQ_N-1:0] IEN_RST = 2'h0;
  localparam logic [DW-1:0] RD_UNMAPPED = 32'h0000_0000;

  typedef enum logic [1:0] {
    ARC_RES_8 = 2'b00,
    ARC_RES_10 = 2'b01,
    ARC_RES_12 = 2'b10
  } arc_res_mode_t;

  typedef enum logic {
    ARC_BUS_IDLE = 1'b0,
    ARC_BUS_ACK = 1'b1
  } arc_bus_state_t;

  // request to the converter core
  typedef struct packed {
    logic start;
    logic start_tgl;
    logic clk_sel;
    arc_res_mode_t mode;
    logic [CH_W-1:0] channel;
  } arc_conv_req_t;

  // completion from a converter on the bus clock
  typedef struct packed {
    logic done;
    logic [RES_W-1:0] data;
  } arc_conv_res_t;

  // completion from a converter on its own clock
  typedef struct packed {
    logic done_tgl;
    logic [RES_W-1:0] data;
  } arc_async_res_t;
endpackage : arc_pkg

//--- rtl/arc_adc_result_ctrl.sv
// module: converter result coherency, completion flag, interrupt and avalon register slave
// Function
// - high-byte read freezes low byte in 10/12-bit
// - completion during high read keeps frozen byte
// - 8-bit result is one byte, no freeze
// - single mode result holds until next completion
// - completion sets flag and loads result
// - status/control write clears flag, completion wins
// - interrupt while enabled and flag set
// - converter on bus clock or own clock
`timescale 1ns/100ps
module arc_adc_result_ctrl (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [arc_pkg::AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [arc_pkg::DW-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [arc_pkg::DW-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire arc_pkg::arc_conv_res_t conv_res,
  input wire arc_pkg::arc_async_res_t async_res,
  output arc_pkg::arc_conv_req_t conv_req,
  output logic irq
);
  import arc_pkg::*;

  logic rst_meta_q;
  logic rst_n_q;
  arc_bus_state_t bus_q;
  logic wait_q;
  logic [DW-1:0] rdata_q;
  logic [DW-1:0] rd_mux;
  logic take;
  logic rd_take;
  logic wr_take;
  logic sel_sc1;
  logic sel_cfg;
  logic sel_resh;
  logic sel_resl;
  logic sel_iclr;
  logic sel_ien;
  logic [CH_W-1:0] ch_q;
  logic cont_q;
  logic aien_q;
  arc_res_mode_t mode_q;
  logic clk_sel_q;
  logic flag_q;
  logic busy_q;
  logic [RES_W-1:0] res_q;
  logic [RES_W-1:0] new_res;
  logic [7:0] hold_lo_q;
  logic frozen_q;
  logic tgl_meta_q;
  logic tgl_sync_q;
  logic tgl_prev_q;
  logic async_evt;
  logic done_evt;
  logic [RES_W-1:0] done_data;
  logic start_d;
  logic start_q;
  logic start_tgl_q;
  logic [IRQ_N-1:0] ist_q;
  logic [IRQ_N-1:0] ien_q;
  logic [IRQ_N-1:0] ev;
  logic irq_q;
  logic [CH_W-1:0] wr_ch;

  // reset release through two flops
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // a request is taken only while waitrequest is high
  assign take = (avs_read | avs_write) & (bus_q == ARC_BUS_IDLE);
  assign rd_take = take & avs_read;
  assign wr_take = take & avs_write & avs_byteenable[0];
  assign wr_ch = avs_writedata[SC1_CH_LSB +: CH_W];

  // address decode, low two address bits ignored
  always_comb begin
    sel_sc1 = 1'b0;
    sel_cfg = 1'b0;
    sel_resh = 1'b0;
    sel_resl = 1'b0;
    sel_iclr = 1'b0;
    sel_ien = 1'b0;
    if (avs_address[AW-1:2] == SC1_OFF[AW-1:2]) begin
      sel_sc1 = 1'b1;
    end else if (avs_address[AW-1:2] == CFG_OFF[AW-1:2]) begin
      sel_cfg = 1'b1;
    end else if (avs_address[AW-1:2] == RESH_OFF[AW-1:2]) begin
      sel_resh = 1'b1;
    end else if (avs_address[AW-1:2] == RESL_OFF[AW-1:2]) begin
      sel_resl = 1'b1;
    end else if (avs_address[AW-1:2] == ICLR_OFF[AW-1:2]) begin
      sel_iclr = 1'b1;
    end else if (avs_address[AW-1:2] == IEN_OFF[AW-1:2]) begin
      sel_ien = 1'b1;
    end
  end

  // bus handshake: one cycle of waitrequest low per taken request
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      bus_q <= ARC_BUS_IDLE;
      wait_q <= 1'b1;
    end else begin
      if (take) begin
        bus_q <= ARC_BUS_ACK;
      end else begin
        bus_q <= ARC_BUS_IDLE;
      end
      wait_q <= ~take;
    end
  end

  // read data selection
  always_comb begin
    rd_mux = RD_UNMAPPED;
    if (sel_sc1) begin
      rd_mux[SC1_FLAG_BIT] = flag_q;
      rd_mux[SC1_AIEN_BIT] = aien_q;
      rd_mux[SC1_CONT_BIT] = cont_q;
      rd_mux[SC1_CH_LSB +: CH_W] = ch_q;
    end else if (sel_cfg) begin
      rd_mux[CFG_MODE_LSB +: 2] = mode_q;
      rd_mux[CFG_CLKSEL_BIT] = clk_sel_q;
      rd_mux[CFG_BUSY_BIT] = busy_q;
    end else if (sel_resh) begin
      if (mode_q != ARC_RES_8) begin
        rd_mux[3:0] = res_q[RES_W-1:8];
      end
    end else if (sel_resl) begin
      if (frozen_q && mode_q != ARC_RES_8) begin
        rd_mux[7:0] = hold_lo_q;
      end else begin
        rd_mux[7:0] = res_q[7:0];
      end
    end else if (avs_address[AW-1:2] == IST_OFF[AW-1:2]) begin
      rd_mux[IRQ_N-1:0] = ist_q;
    end else if (sel_ien) begin
      rd_mux[IRQ_N-1:0] = ien_q;
    end
  end

  // read data register, held until the next taken read
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata_q <= RD_UNMAPPED;
    end else if (rd_take) begin
      rdata_q <= rd_mux;
    end
  end

  // bus outputs straight from their flops
  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;

  // own-clock completion toggle: two-flop sync then edge detect
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tgl_meta_q <= 1'b0;
      tgl_sync_q <= 1'b0;
      tgl_prev_q <= 1'b0;
    end else begin
      tgl_meta_q <= async_res.done_tgl;
      tgl_sync_q <= tgl_meta_q;
      tgl_prev_q <= tgl_sync_q;
    end
  end

  // one-cycle event per toggle; data is held steady by the converter, so not resynchronised
  assign async_evt = tgl_sync_q ^ tgl_prev_q;

  // completion source follows the selected converter clock
  assign done_evt = clk_sel_q ? async_evt : conv_res.done;
  assign done_data = clk_sel_q ? async_res.data : conv_res.data;

  // trim the result to the active resolution
  always_comb begin
    case (mode_q)
      ARC_RES_8: begin
        new_res = {4'h0, done_data[7:0]};
      end
      ARC_RES_10: begin
        new_res = {2'h0, done_data[9:0]};
      end
      default: begin
        new_res = done_data;
      end
    endcase
  end

  // control fields of converter_status_control_one
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ch_q <= CH_RST;
      cont_q <= 1'b0;
      aien_q <= 1'b0;
    end else if (wr_take && sel_sc1) begin
      ch_q <= wr_ch;
      cont_q <= avs_writedata[SC1_CONT_BIT];
      aien_q <= avs_writedata[SC1_AIEN_BIT];
    end
  end

  // resolution and converter clock selection
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mode_q <= ARC_RES_8;
      clk_sel_q <= 1'b0;
    end else if (wr_take && sel_cfg) begin
      mode_q <= arc_res_mode_t'(avs_writedata[CFG_MODE_LSB +: 2]);
      clk_sel_q <= avs_writedata[CFG_CLKSEL_BIT];
    end
  end

  // conversion complete flag: a completion beats any clear
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      flag_q <= 1'b0;
    end else if (done_evt) begin
      flag_q <= 1'b1;
    end else if (wr_take && sel_sc1) begin
      flag_q <= 1'b0;
    end else if (rd_take && sel_resl) begin
      flag_q <= 1'b0; // reading the low result byte also acknowledges it
    end
  end

  // result register only changes on a completion
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      res_q <= '0;
    end else if (done_evt) begin
      res_q <= new_res;
    end
  end

  // low byte snapshot taken from the pre-completion value on a high read
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      hold_lo_q <= 8'h00;
      frozen_q <= 1'b0;
    end else if (rd_take && sel_resh && mode_q != ARC_RES_8) begin
      hold_lo_q <= res_q[7:0];
      frozen_q <= 1'b1;
    end else if ((rd_take && sel_resl) || (wr_take && sel_cfg)) begin
      frozen_q <= 1'b0;
    end
  end

  // starts: a write with a live channel, or a continuous re-arm
  always_comb begin
    start_d = 1'b0;
    if (wr_take && sel_sc1) begin
      start_d = (wr_ch != CH_OFF);
    end else if (done_evt && cont_q && ch_q != CH_OFF) begin
      start_d = 1'b1;
    end
  end

  // start pulse for a bus-clock converter, toggle for an own-clock one
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      start_q <= 1'b0;
      start_tgl_q <= 1'b0;
    end else begin
      start_q <= start_d;
      start_tgl_q <= start_tgl_q ^ start_d;
    end
  end

  // conversion in progress between a start and its completion
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      busy_q <= 1'b0;
    end else if (start_d) begin
      busy_q <= 1'b1;
    end else if (done_evt) begin
      busy_q <= 1'b0;
    end
  end

  // converter request fields, all from flops
  assign conv_req.start = start_q;
  assign conv_req.start_tgl = start_tgl_q;
  assign conv_req.clk_sel = clk_sel_q;
  assign conv_req.mode = mode_q;
  assign conv_req.channel = ch_q;

  // interrupt events: completion, and completion over an unread result
  assign ev[IST_DONE_BIT] = done_evt;
  assign ev[IST_OVR_BIT] = done_evt & flag_q;

  // sticky status bits, set wins over a write-one clear
  generate
    for (genvar i = 0; i < IRQ_N; i++) begin : g_ist
      always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
          ist_q[i] <= 1'b0;
        end else if (ev[i]) begin
          ist_q[i] <= 1'b1;
        end else if (wr_take && sel_iclr && avs_writedata[i]) begin
          ist_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // interrupt enable register
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ien_q <= IEN_RST;
    end else if (wr_take && sel_ien) begin
      ien_q <= avs_writedata[IRQ_N-1:0];
    end
  end

  // level interrupt from the flag while aien is set, or from any enabled sticky bit
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (flag_q & aien_q) | (|(ist_q & ien_q));
    end
  end

  // interrupt output from its flop
  assign irq = irq_q;
endmodule : arc_adc_result_ctrl

//--- verification/arc_conv_model.sv
// converter model: answers each start after a set delay on either completion link
`timescale 1ns/100ps
module arc_conv_model (
  input wire logic core_clk,
  input wire logic resetn,
  input wire arc_pkg::arc_conv_req_t conv_req,
  input wire logic [3:0] dly,
  input wire logic [arc_pkg::RES_W-1:0] val,
  output logic [3:0] cnt,
  output arc_pkg::arc_conv_res_t conv_res,
  output arc_pkg::arc_async_res_t async_res
);
  import arc_pkg::*;
  logic [RES_W-1:0] data_q;
  logic done_q;
  logic tgl_q;
  // conversion timer, sample taken at start and held until the next start
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= 4'h0;
      data_q <= 12'h000;
    end else if (conv_req.start) begin
      cnt <= dly;
      data_q <= val;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end
  end
  // completion as a pulse on the bus clock or a toggle from the own clock
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      done_q <= 1'b0;
      tgl_q <= 1'b0;
    end else begin
      done_q <= cnt == 4'h1 && !conv_req.clk_sel;
      if (cnt == 4'h1 && conv_req.clk_sel) tgl_q <= !tgl_q;
    end
  end
  // pulse data only valid with done, toggle data stable from start
  assign conv_res = {done_q, done_q ? data_q : ~data_q};
  assign async_res = {tgl_q, data_q};
endmodule : arc_conv_model

//--- verification/arc_adc_result_ctrl_props.sv
// checker: bus answer, start pulses, read values and interrupt causes
`timescale 1ns/100ps
module arc_adc_result_ctrl_props (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [arc_pkg::AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [arc_pkg::DW-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [arc_pkg::DW-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire arc_pkg::arc_conv_res_t conv_res,
  input wire arc_pkg::arc_async_res_t async_res,
  input wire arc_pkg::arc_conv_req_t conv_req,
  input wire logic irq
);
  import arc_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // taken request, taken status/control write, one-cycle answer
  sequence s_take;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_wsc1;
    avs_write && avs_waitrequest && avs_address[4:2] == 3'h0 && avs_byteenable[0];
  endsequence
  sequence s_ack;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  chk_wait_one: assert property (s_take |=> s_ack) else $error("bus answer late");
  chk_start_pulse: assert property (conv_req.start |=> !conv_req.start) else $error("long start");
  chk_sc1_start: assert property (s_wsc1 ##0 avs_writedata[4:0] != CH_OFF
    |=> conv_req.start) else $error("no start");
  chk_off_idle: assert property (s_wsc1 ##0 avs_writedata[4:0] == CH_OFF |=> !conv_req.start)
    else $error("start while off");
  chk_unmapped_zero: assert property (avs_read && avs_waitrequest && avs_address[4:2] == 3'h7
    |=> avs_readdata == RD_UNMAPPED) else $error("unmapped read");
  chk_res8_high: assert property (avs_read && avs_waitrequest &&
    avs_address[4:2] == 3'h2 && conv_req.mode == ARC_RES_8 |=> avs_readdata == 32'h0)
    else $error("8-bit high byte");
  chk_irq_rise: assert property (disable iff (!resetn || conv_req.clk_sel)
    $rose(irq) |-> $past(conv_res.done, 2) || $past(avs_write && avs_waitrequest, 2))
    else $error("irq cause");
  chk_irq_fall: assert property ($fell(irq) |-> $past(avs_waitrequest &&
    (avs_write || avs_read), 2)) else $error("irq drop");
  // the own-clock start toggle steps exactly when the start pulse stands
  chk_tgl_step: assert property ((conv_req.start_tgl ^ $past(conv_req.start_tgl)) ==
    conv_req.start) else $error("start toggle");
endmodule : arc_adc_result_ctrl_props
bind arc_adc_result_ctrl arc_adc_result_ctrl_props u_props (.core_clk, .resetn, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
  .conv_res, .async_res, .conv_req, .irq);

//--- verification/tb.sv
// testbench: register traffic and converter completions against the result controller
`timescale 1ns/100ps
module tb;
  import arc_pkg::*;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [AW-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [DW-1:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [DW-1:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  logic [RES_W-1:0] val = 12'h000;
  logic [3:0] dly = 4'h6;
  logic [3:0] cnt;
  logic [DW-1:0] rdv;
  arc_conv_res_t conv_res;
  arc_async_res_t async_res;
  arc_conv_req_t conv_req;
  int err_count = 0;
  int comparisons = 0;
  always #5 core_clk = ~core_clk;
  arc_adc_result_ctrl dut (.core_clk, .resetn, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .conv_res,
    .async_res, .conv_req, .irq);
  arc_conv_model u_conv (.core_clk, .resetn, .conv_req, .dly, .val, .cnt, .conv_res,
    .async_res);
  task summarize;
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  task chk(string n, logic [DW-1:0] e, logic [DW-1:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %0h seen %0h", n, e, g);
    end
  endtask : chk
  // one bus transfer, started at an edge, held until waitrequest is seen low
  task bus(logic w, logic [AW-1:0] a, logic [7:0] d);
    int i;
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    i = 0;
    do begin
      @(posedge core_clk);
      i++;
    end while (avs_waitrequest !== 1'b0 && i < 20);
    if (i >= 20) begin
      err_count++;
      summarize();
    end
    rdv = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask : bus
  task rdc(string n, logic [AW-1:0] a, logic [DW-1:0] e);
    bus(1'b0, a, 8'h00);
    chk(n, e, rdv);
  endtask : rdc
  // wait for the edge just before a completion, then some more edges
  task wdone(int extra);
    int i;
    i = 0;
    // step an edge first, so back-to-back calls see the next conversion
    do begin
      @(posedge core_clk);
      i++;
    end while (cnt !== 4'h1 && i < 60);
    if (i >= 60) begin
      err_count++;
      summarize();
    end
    repeat (extra) @(posedge core_clk);
  endtask : wdone
  task t_res12;
    val <= 12'hA5C;
    bus(1'b1, CFG_OFF, 8'h02);
    bus(1'b1, SC1_OFF, 8'h43);
    wdone(3);
    chk("irq", 1, irq);
    rdc("sc1", SC1_OFF, 32'hC3);
    rdc("hi12", RESH_OFF, 32'hA);
    rdc("lo12", RESL_OFF, 32'h5C);
    rdc("ist", IST_OFF, 32'h1);
    bus(1'b1, IEN_OFF, 8'h01);
    chk("irq_en", 32'h1, irq);
    bus(1'b1, ICLR_OFF, 8'h01);
    chk("irq_clr", 32'h0, irq);
    bus(1'b1, IEN_OFF, 8'h00);
    val <= 12'h111;
    repeat (20) @(posedge core_clk);
    rdc("hold", RESL_OFF, 32'h5C);
  endtask : t_res12
  task t_flag;
    bus(1'b1, SC1_OFF, 8'h43);
    wdone(0);
    bus(1'b1, SC1_OFF, 8'h5F);
    chk("irq_kept", 1, irq);
    rdc("sc1_kept", SC1_OFF, 32'hDF);
    bus(1'b1, SC1_OFF, 8'h1F);
    rdc("sc1_clr", SC1_OFF, 32'h1F);
    chk("irq_off", 0, irq);
  endtask : t_flag
  task t_coh;
    val <= 12'hE5A;
    bus(1'b1, CFG_OFF, 8'h01);
    bus(1'b1, SC1_OFF, 8'h23);
    wdone(0);
    val <= 12'h3C3;
    wdone(0);
    rdc("hi10", RESH_OFF, 32'h2);
    rdc("lo10", RESL_OFF, 32'h5A);
    rdc("ist_ovr", IST_OFF, 32'h3);
    bus(1'b1, SC1_OFF, 8'h1F);
    bus(1'b1, SC1_OFF, 8'h1F);
    repeat (20) @(posedge core_clk);
  endtask : t_coh
  task t_res8;
    val <= 12'hFB7;
    bus(1'b1, CFG_OFF, 8'h00);
    bus(1'b1, SC1_OFF, 8'h03);
    wdone(3);
    rdc("hi8", RESH_OFF, 32'h0);
    rdc("lo8", RESL_OFF, 32'hB7);
  endtask : t_res8
  task t_async;
    val <= 12'h9E1;
    bus(1'b1, CFG_OFF, 8'h06);
    bus(1'b1, SC1_OFF, 8'h03);
    wdone(6);
    rdc("hi_as", RESH_OFF, 32'h9);
    rdc("lo_as", RESL_OFF, 32'hE1);
  endtask : t_async
  initial begin
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk("irq_rst", 0, irq);
    rdc("sc1_rst", SC1_OFF, 32'h1F);
    rdc("unmapped", 5'h1C, 32'h0);
    t_res12();
    t_flag();
    t_coh();
    t_res8();
    t_async();
    summarize();
  end
endmodule : tb
